// >>> common/ge_defines.vh
`ifndef GE_DEFINES_VH
`define GE_DEFINES_VH

// Configuration dword holding status (low half) and enable (high half)
`define GE_EVENT_DWORD 8'ha8
`define GE_STATUS_OFFSET 8'ha8
`define GE_ENABLE_OFFSET 8'haa
`define GE_EVENT_FUNC 3'h0

// Field positions inside status and enable
`define GE_SOCK0_VIDEO_BIT 15
`define GE_SOCK1_VIDEO_BIT 14
`define GE_POWER_BIT 11
`define GE_PROG_VOLT_BIT 8
`define GE_INPUT_MSB 4
`define GE_INPUT_LSB 0

// Implemented bits; all others read zero
`define GE_IMPL_MASK 16'hc91f
`define GE_STATUS_RESET 16'h0000
`define GE_ENABLE_RESET 16'h0000

// Synchroniser depth for terminal inputs
`define GE_SYNC_STAGES 2

`endif

// >>> logic/ge_change_detect.v
`timescale 1ns/1ps
`default_nettype none

module ge_change_detect #(
  parameter WIDTH = 5,
  parameter SYNC = 1
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] level_in,
  output wire [WIDTH-1:0] changed
);

  // Hold off until the sync stages carry a real sample, so reset levels are not changes
  localparam [1:0] PRIME = (SYNC != 0) ? 2'd3 : 2'd1;

  reg [1:0] prime_cnt;
  wire primed;
  reg [WIDTH-1:0] prev;
  wire [WIDTH-1:0] sampled;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prime_cnt <= 2'd0;
    end else if (prime_cnt != PRIME) begin
      prime_cnt <= prime_cnt + 2'd1;
    end
  end

  assign primed = (prime_cnt == PRIME);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      if (SYNC != 0) begin : g_sync
        reg meta;
        reg stable;
        // First stage feeds only the second stage
        always @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            meta <= 1'b0;
            stable <= 1'b0;
          end else begin
            meta <= level_in[i];
            stable <= meta;
          end
        end
        assign sampled[i] = stable;
      end else begin : g_direct
        assign sampled[i] = level_in[i];
      end

      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          prev[i] <= 1'b0;
        end else begin
          prev[i] <= sampled[i];
        end
      end

      // No edge until a real previous sample exists, so reset is not a change
      assign changed[i] = primed & (prev[i] ^ sampled[i]); // RULE16
    end
  endgenerate

endmodule

`default_nettype wire

// >>> logic/ge_event_logic.v
// Summary of operation
// RULE1: One sticky status bit per event source, set when its event occurs.
// RULE2: Writing one clears a status bit and its output share; zero keeps it.
// RULE3: Status bits set regardless of the matching enable bit.
// RULE4: Software reaches these registers only through function 0, never function 1.
// RULE5: Bit 15 sets on any change of socket 0 video port enable.
// RULE6: Bit 14 sets on any change of socket 1 video port enable.
// RULE7: Bit 11 sets when either socket's supply or programming voltage changes.
// RULE8: Bit 8 sets when either socket's programming voltage enters or leaves 12 V.
// RULE9: Bits 4 to 0 set on any level change of their input terminals.
// RULE10: Bits 13-12, 10-9 and 7-5 of both registers read zero, ignore writes.
// RULE11: Enable bits are read/write; set enable lets a status event drive the output.
// RULE12: The event output stays asserted until software clears the status bit.
// RULE13: The event output reaches a pin only if some terminal carries it.
// RULE14: Input enables count only when their terminal is set as general input.
// RULE15: Both registers reset to zero; output low when status and enable coincide.
// RULE16: Terminal inputs are synchronised before edge detection; one set per change.
`timescale 1ns/1ps
`default_nettype none
`include "ge_defines.vh"

module ge_event_logic #(
  parameter PWR_W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire cfg_req,
  input wire cfg_we,
  input wire [2:0] cfg_func,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  input wire [1:0] socket_video_port_on,
  input wire [PWR_W-1:0] socket_power_setting,
  input wire [1:0] prog_volt_high_req,
  input wire [4:0] gen_input,
  input wire [4:0] gen_input_selected,
  input wire event_pin_selected,
  output reg [31:0] cfg_rdata,
  output reg cfg_ack,
  output reg gen_event_out_n
);

  reg [15:0] event_status;
  reg [15:0] event_enable;
  reg [15:0] next_status;
  reg [15:0] next_enable;
  reg [15:0] set_vec;
  reg [15:0] clear_vec;
  reg [15:0] enable_eff;

  wire [1:0] video_chg;
  wire [PWR_W-1:0] power_chg;
  wire [1:0] volt_chg;
  wire [4:0] input_chg;
  wire hit;
  wire [7:0] event_dword;

  assign event_dword = `GE_EVENT_DWORD;

  // Internal register levels are already on this clock
  ge_change_detect #(.WIDTH(PWR_W + 4), .SYNC(0)) u_internal_chg (
    .clk(clk),
    .reset_n(reset_n),
    .level_in({prog_volt_high_req, socket_power_setting, socket_video_port_on}),
    .changed({volt_chg, power_chg, video_chg})
  );

  ge_change_detect #(.WIDTH(5), .SYNC(1)) u_input_chg (
    .clk(clk),
    .reset_n(reset_n),
    .level_in(gen_input),
    .changed(input_chg) // RULE16
  );

  // Function 1 is not decoded; its accesses read zero and write nothing
  assign hit = cfg_req & (cfg_func == `GE_EVENT_FUNC)
    & (cfg_addr[7:2] == event_dword[7:2]); // RULE4

  always @* begin
    set_vec = 16'h0000;
    set_vec[`GE_SOCK0_VIDEO_BIT] = video_chg[0]; // RULE5
    set_vec[`GE_SOCK1_VIDEO_BIT] = video_chg[1]; // RULE6
    set_vec[`GE_POWER_BIT] = |power_chg; // RULE7
    set_vec[`GE_PROG_VOLT_BIT] = |volt_chg; // RULE8
    set_vec[`GE_INPUT_MSB:`GE_INPUT_LSB] = input_chg; // RULE9
  end

  always @* begin
    clear_vec = 16'h0000;
    next_enable = event_enable;
    if (hit && cfg_we) begin
      if (cfg_be[0]) begin
        clear_vec[7:0] = cfg_wdata[7:0]; // RULE2
      end
      if (cfg_be[1]) begin
        clear_vec[15:8] = cfg_wdata[15:8];
      end
      if (cfg_be[2]) begin
        next_enable[7:0] = cfg_wdata[23:16]; // RULE11
      end
      if (cfg_be[3]) begin
        next_enable[15:8] = cfg_wdata[31:24];
      end
    end
    next_enable = next_enable & `GE_IMPL_MASK; // RULE10
    // Set wins over a clear in the same cycle so no event is lost
    next_status = ((event_status & ~clear_vec) | set_vec) & `GE_IMPL_MASK; // RULE1 RULE3
  end

  always @* begin
    enable_eff = event_enable;
    enable_eff[`GE_INPUT_MSB:`GE_INPUT_LSB] =
      event_enable[`GE_INPUT_MSB:`GE_INPUT_LSB] & gen_input_selected; // RULE14
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_status <= `GE_STATUS_RESET; // RULE15
      event_enable <= `GE_ENABLE_RESET;
    end else begin
      event_status <= next_status;
      event_enable <= next_enable;
    end
  end

  // Output follows the sticky status, so it holds until cleared
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_event_out_n <= 1'b1;
    end else begin
      gen_event_out_n <= ~(event_pin_selected & |(event_status & enable_eff)); // RULE12 RULE13 RULE15
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h00000000;
    end else begin
      cfg_ack <= cfg_req;
      if (cfg_req && !cfg_we && hit) begin
        cfg_rdata <= {event_enable, event_status};
      end else begin
        cfg_rdata <= 32'h00000000;
      end
    end
  end

endmodule

`default_nettype wire

// >>> tb/ge_event_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ge_event_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_func,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic event_pin_selected,
  input wire logic gen_event_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ack_late_a: assert property (cfg_req |=> cfg_ack) else $error("ack");
  ack_cause_a: assert property (cfg_ack |-> $past(cfg_req)) else $error("ack");
  rdata_idle_a: assert property (!cfg_ack |-> cfg_rdata == 32'h0) else $error("rd");
  func_zero_a: assert property (cfg_req && cfg_func != 3'h0 |=> cfg_rdata == 32'h0)
    else $error("fn");
  rsvd_zero_a: assert property ((cfg_rdata & 32'h36e036e0) == 32'h0) else $error("rs");
  pin_gate_a: assert property (!event_pin_selected |=> gen_event_out_n) else $error("pin");
  // Release needs a write two edges back or a dropped pin
  event_hold_a: assert property ($rose(gen_event_out_n) |->
    !$past(event_pin_selected) || $past(cfg_req && cfg_we, 2)) else $error("hold");
  event_cause_a: assert property ($fell(gen_event_out_n) |->
    $past(event_pin_selected)) else $error("fell");
endmodule
`default_nettype wire

// >>> tb/ge_host.sv
`timescale 1ns/1ps
`default_nettype none
module ge_host (
  input wire logic clk,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_req = 1'b0,
  output logic cfg_we = 1'b0,
  output logic [2:0] cfg_func = 3'h0,
  output logic [7:0] cfg_addr = 8'h0,
  output logic [3:0] cfg_be = 4'h0,
  output logic [31:0] cfg_wdata = 32'h0
);
  // A missing ack shows up as a bad read value
  task automatic acc(input logic [47:0] c, output logic [31:0] q);
    @(negedge clk);
    {cfg_req, cfg_we, cfg_func, cfg_addr, cfg_be, cfg_wdata} = {1'b1, c};
    @(negedge clk);
    q = cfg_ack ? cfg_rdata : 32'hbad0bad0;
    {cfg_req, cfg_wdata} = {1'b0, ~cfg_wdata};
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, reset_n = 0, event_pin_selected = 1;
  logic [1:0] socket_video_port_on = 0, prog_volt_high_req = 0;
  logic [7:0] socket_power_setting = 0, cfg_addr;
  logic [4:0] gen_input = 0, gen_input_selected = 5'h1f;
  logic cfg_req, cfg_we, cfg_ack, gen_event_out_n;
  logic [2:0] cfg_func;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, r;
  logic [15:0] st = 0, en = 0;
  int n_mismatch = 0, comparisons = 0;
  int bits[9] = '{15, 14, 11, 8, 4, 3, 2, 1, 0};
  always #5 clk = ~clk;
  ge_host host (.clk, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_we, .cfg_func, .cfg_addr, .cfg_be,
    .cfg_wdata);
  ge_event_logic dut (.clk, .reset_n, .cfg_req, .cfg_we, .cfg_func, .cfg_addr, .cfg_be,
    .cfg_wdata, .socket_video_port_on, .socket_power_setting, .prog_volt_high_req, .gen_input,
    .gen_input_selected, .event_pin_selected, .cfg_rdata, .cfg_ack, .gen_event_out_n);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic look();
    host.acc({1'b0, 3'h0, 8'ha8, 4'hf, 32'h0}, r);
    check(r, {en, st});
    check(gen_event_out_n, !(event_pin_selected && |(st & en & {11'h7ff, gen_input_selected})));
  endtask
  task automatic wr(input logic [31:0] d);
    host.acc({1'b1, 3'h0, 8'ha8, 4'hf, d}, r);
    st = st & ~d[15:0];
    en = d[31:16] & 16'hc91f;
    repeat (2) @(negedge clk);
  endtask
  task automatic tog(input int b);
    case (b)
      15: socket_video_port_on[0] = ~socket_video_port_on[0];
      14: socket_video_port_on[1] = ~socket_video_port_on[1];
      11: socket_power_setting[$urandom % 8] ^= 1'b1;
      8: prog_volt_high_req[$urandom % 2] ^= 1'b1;
      default: gen_input[b] = ~gen_input[b];
    endcase
    repeat (5) @(negedge clk);
    st[b] = 1'b1;
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9722));
    repeat (4) @(negedge clk);
    reset_n = 1;
    look();
    wr(32'hffff_0000);
    look();
    foreach (bits[i]) begin
      tog(bits[i]);
      look();
      wr({en, 16'h1 << bits[i]});
      look();
    end
    $display("test sources done");
    wr(32'h0);
    tog(15);
    look();
    wr(32'h8000_0000);
    look();
    event_pin_selected = 0;
    repeat (2) @(negedge clk);
    look();
    event_pin_selected = 1;
    gen_input_selected = 5'h0;
    wr(32'h0001_8000);
    tog(0);
    look();
    $display("test gating done");
    host.acc({1'b1, 3'h1, 8'ha8, 4'hf, 32'hffff_ffff}, r);
    host.acc({1'b0, 3'h1, 8'ha8, 4'hf, 32'h0}, r);
    check(r, 32'h0);
    host.acc({1'b0, 3'h0, 8'hb0, 4'hf, 32'h0}, r);
    check(r, 32'h0);
    look();
    $display("test function done");
    reset_n = 0;
    gen_input = ~gen_input;
    st = 0;
    en = 0;
    repeat (2) @(negedge clk);
    reset_n = 1;
    repeat (6) @(negedge clk);
    look();
    $display("test reset done");
    print_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
endmodule
bind ge_event_logic ge_event_chk chk (.clk, .reset_n, .cfg_req, .cfg_we, .cfg_func,
  .cfg_rdata, .cfg_ack, .event_pin_selected, .gen_event_out_n);
`default_nettype wire
